// ===== gpcfg_regs.svh
`ifndef GPCFG_REGS_SVH
`define GPCFG_REGS_SVH

`define GPCFG_OFS_DRIVE     8'h04
`define GPCFG_OFS_SPEED     8'h08
`define GPCFG_OFS_PULL      8'h0C
`define GPCFG_OFS_SAMPLE    8'h10
`define GPCFG_OFS_LATCH     8'h14
`define GPCFG_OFS_SETCLR    8'h18
`define GPCFG_OFS_FREEZE    8'h1C

`define GPCFG_RST_SPEED_FIRST 32'h0C00_0000
`define GPCFG_RST_PULL_FIRST  32'h2400_0000
`define GPCFG_RST_ZERO        32'h0000_0000

`define GPCFG_KEY_BIT       16
`define GPCFG_PINS          16

`endif

// ===== gpcfg_pkg.sv
package gpcfg_pkg;

  // Register bus request carried as one group
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } gpcfg_req_type;

  typedef enum logic [1:0] {
    GPCFG_SPD_LOW  = 2'b00,
    GPCFG_SPD_MID  = 2'b01,
    GPCFG_SPD_HIGH = 2'b11
  } gpcfg_speed_type;

  typedef enum logic [1:0] {
    GPCFG_PULL_NONE = 2'b00,
    GPCFG_PULL_UP   = 2'b01,
    GPCFG_PULL_DOWN = 2'b10
  } gpcfg_pull_type;

  // Freeze key sequence: write 1, write 1, read 0, read 1
  typedef enum logic [2:0] {
    GPCFG_KEY_IDLE = 3'b000,
    GPCFG_KEY_W1   = 3'b001,
    GPCFG_KEY_W2   = 3'b010,
    GPCFG_KEY_R1   = 3'b011,
    GPCFG_KEY_ON   = 3'b100
  } gpcfg_key_type;

endpackage

// ===== gpcfg_port.sv
`timescale 1ns/100ps
`include "gpcfg_regs.svh"
module gpcfg_port
  import gpcfg_pkg::*;
#(
  parameter int PORT_INDEX = 0
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  // Register access
  input  wire gpcfg_req_type bus_req,
  output logic [31:0]        bus_rdata,
  // Pads
  input  wire logic [15:0]   pad_in,
  output logic [15:0]        pad_out,
  output logic [15:0]        pad_oe,
  // Configuration seen by the pad cells
  output logic [31:0]        speed_field,
  output logic [31:0]        pull_field,
  output logic [15:0]        drive_type_bit
);

  localparam logic [31:0] SPEED_RST = (PORT_INDEX == 0) ? `GPCFG_RST_SPEED_FIRST
                                                        : `GPCFG_RST_ZERO;
  localparam logic [31:0] PULL_RST  = (PORT_INDEX == 0) ? `GPCFG_RST_PULL_FIRST
                                                        : `GPCFG_RST_ZERO;
  localparam bit HAS_FREEZE = (PORT_INDEX < 2);

  logic [15:0]   drive_r;
  logic [31:0]   speed_r;
  logic [31:0]   pull_r;
  logic [15:0]   latch_r;
  logic [15:0]   pad_meta_r;
  logic [15:0]   pad_sync_r;
  logic [15:0]   sample_r;
  logic [15:0]   freeze_bits_r;
  gpcfg_key_type key_r;
  gpcfg_key_type key_nxt;
  logic [31:0]   rdata_nxt;

  // Byte-enable mask expanded to bits
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  wire        wr_go     = bus_req.sel & bus_req.wr;
  wire        rd_go     = bus_req.sel & ~bus_req.wr;
  wire [31:0] wmask     = lane_mask(bus_req.be);
  wire        key_on    = (key_r == GPCFG_KEY_ON);
  wire [31:0] lock2     = {{2{freeze_bits_r[15]}}, {2{freeze_bits_r[14]}},
                           {2{freeze_bits_r[13]}}, {2{freeze_bits_r[12]}},
                           {2{freeze_bits_r[11]}}, {2{freeze_bits_r[10]}},
                           {2{freeze_bits_r[9]}},  {2{freeze_bits_r[8]}},
                           {2{freeze_bits_r[7]}},  {2{freeze_bits_r[6]}},
                           {2{freeze_bits_r[5]}},  {2{freeze_bits_r[4]}},
                           {2{freeze_bits_r[3]}},  {2{freeze_bits_r[2]}},
                           {2{freeze_bits_r[1]}},  {2{freeze_bits_r[0]}}};
  wire [31:0] frz2      = key_on ? lock2 : 32'h0000_0000;
  wire [15:0] frz1      = key_on ? freeze_bits_r : 16'h0000;
  wire [31:0] cfg_wmask = wmask & ~frz2;
  wire [15:0] drv_wmask = wmask[15:0] & ~frz1;

  wire wr_drive  = wr_go & (bus_req.addr == `GPCFG_OFS_DRIVE);
  wire wr_speed  = wr_go & (bus_req.addr == `GPCFG_OFS_SPEED);
  wire wr_pull   = wr_go & (bus_req.addr == `GPCFG_OFS_PULL);
  wire wr_latch  = wr_go & (bus_req.addr == `GPCFG_OFS_LATCH);
  wire wr_setclr = wr_go & (bus_req.addr == `GPCFG_OFS_SETCLR);
  wire frz_hit   = HAS_FREEZE & (bus_req.addr == `GPCFG_OFS_FREEZE);
  wire wr_frz    = wr_go & frz_hit & ~key_on & (&bus_req.be[2:0]);
  wire rd_frz    = rd_go & frz_hit;
  wire wr_key1   = wr_frz & bus_req.wdata[`GPCFG_KEY_BIT]
                   & (bus_req.wdata[15:0] == freeze_bits_r);
  wire [15:0] set_req = wr_setclr ? (bus_req.wdata[15:0] & wmask[15:0]) : 16'h0000;
  wire [15:0] clr_req = wr_setclr ? (bus_req.wdata[31:16] & wmask[31:16]) : 16'h0000;

  // Drive, speed and pull writes update only enabled, unfrozen bits; latch writes update enabled bits, frozen or not
  wire [15:0] drive_nxt = wr_drive ? ((drive_r & ~drv_wmask) | (bus_req.wdata[15:0] & drv_wmask))
                                   : drive_r;
  wire [31:0] speed_nxt = wr_speed ? ((speed_r & ~cfg_wmask) | (bus_req.wdata & cfg_wmask))
                                   : speed_r;
  wire [31:0] pull_nxt  = wr_pull ? ((pull_r & ~cfg_wmask) | (bus_req.wdata & cfg_wmask))
                                  : pull_r;
  wire [15:0] latch_wr  = wr_latch ? ((latch_r & ~wmask[15:0]) | (bus_req.wdata[15:0] & wmask[15:0]))
                                   : latch_r;
  // Clear applied first so a set on the same pin wins
  wire [15:0] latch_nxt = (latch_wr & ~clr_req) | set_req;

  // Sequence restarts on any freeze access that breaks it, pin bits must hold
  always_comb begin
    key_nxt = key_r;
    unique case (key_r)
      GPCFG_KEY_IDLE: if (wr_key1) key_nxt = GPCFG_KEY_W1;
      GPCFG_KEY_W1:   if (wr_frz) key_nxt = wr_key1 ? GPCFG_KEY_W2 : GPCFG_KEY_IDLE;
                      else if (rd_frz) key_nxt = GPCFG_KEY_IDLE;
      GPCFG_KEY_W2:   if (rd_frz) key_nxt = GPCFG_KEY_R1;
                      else if (wr_frz) key_nxt = wr_key1 ? GPCFG_KEY_W1 : GPCFG_KEY_IDLE;
      GPCFG_KEY_R1:   if (rd_frz) key_nxt = GPCFG_KEY_ON;
                      else if (wr_frz) key_nxt = wr_key1 ? GPCFG_KEY_W1 : GPCFG_KEY_IDLE;
      GPCFG_KEY_ON:   key_nxt = GPCFG_KEY_ON;
      default:        key_nxt = GPCFG_KEY_IDLE;
    endcase
  end

  // Read data; the key reads 0 on the first read of the sequence
  wire key_rd = (key_r == GPCFG_KEY_R1) | key_on;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_go) begin
      unique case (bus_req.addr)
        `GPCFG_OFS_DRIVE:  rdata_nxt = {16'h0000, drive_r};
        `GPCFG_OFS_SPEED:  rdata_nxt = speed_r;
        `GPCFG_OFS_PULL:   rdata_nxt = pull_r;
        `GPCFG_OFS_SAMPLE: rdata_nxt = {16'h0000, sample_r};
        `GPCFG_OFS_LATCH:  rdata_nxt = {16'h0000, latch_r};
        `GPCFG_OFS_SETCLR: rdata_nxt = 32'h0000_0000;
        `GPCFG_OFS_FREEZE: rdata_nxt = HAS_FREEZE ? {15'h0000, key_rd, freeze_bits_r}
                                                  : 32'h0000_0000;
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      drive_r   <= 16'h0000;
      speed_r   <= SPEED_RST;
      pull_r    <= PULL_RST;
      latch_r   <= 16'h0000;
      key_r     <= GPCFG_KEY_IDLE;
      bus_rdata <= 32'h0000_0000;
    end else begin
      drive_r   <= drive_nxt;
      speed_r   <= speed_nxt;
      pull_r    <= pull_nxt;
      latch_r   <= latch_nxt;
      key_r     <= key_nxt;
      bus_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      freeze_bits_r <= 16'h0000;
    end else if (wr_frz) begin
      freeze_bits_r <= bus_req.wdata[15:0];
    end
  end

  // Pads are asynchronous: two stages, then the sample register (no reset, undefined)
  always_ff @(posedge clk_sys) begin
    pad_meta_r <= pad_in;
    pad_sync_r <= pad_meta_r;
    sample_r   <= pad_sync_r;
  end

  // Open-drain releases the pad for a one, push-pull always drives
  assign pad_out        = latch_r;
  assign pad_oe         = ~(drive_r & latch_r);
  assign speed_field    = speed_r;
  assign pull_field     = pull_r;
  assign drive_type_bit = drive_r;

  a_latch_set_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
    set_req[7] |=> latch_r[7]) else $error("set request did not set latch");
  a_latch_clr_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clr_req[7] && !set_req[7] && !(wr_latch && bus_req.be[0]))
    |=> !latch_r[7]) else $error("clear request did not clear latch");
  a_sample_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##3 sample_r == $past(pad_in, 3)) else $error("sample lags pad by wrong amount");
  a_od_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (drive_r[0] && latch_r[0]) |-> !pad_oe[0]) else $error("open drain drove high");
  a_pp_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !drive_r[2] |-> pad_oe[2] && pad_out[2] == latch_r[2]) else $error("push-pull not driven");
  a_setclr_reads0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_go && bus_req.addr == `GPCFG_OFS_SETCLR) |=> bus_rdata == 32'h0000_0000)
    else $error("set/clear register read nonzero");
  a_key_sticks: assert property (@(posedge clk_sys) disable iff (sys_rst)
    key_on |=> key_on && $stable(freeze_bits_r)) else $error("freeze key dropped");
  a_frozen_speed: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (key_on && freeze_bits_r[0]) |=> speed_r[1:0] == $past(speed_r[1:0]))
    else $error("frozen speed field changed");
  a_sample_upper0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_go && bus_req.addr == `GPCFG_OFS_SAMPLE) |=> bus_rdata[31:16] == 16'h0000)
    else $error("sample upper half nonzero");

endmodule // gpcfg_port

// ===== gpcfg_pads.sv
`timescale 1ns/100ps
module gpcfg_pads
  import gpcfg_pkg::*;
(
  // Port side
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  input  wire logic [31:0] pull_field,
  // Board side
  input  wire logic [15:0] board_level,
  output logic [15:0]      pad_level
);
  // A floating pin follows its pull resistor, else whatever the board holds
  always_comb begin
    for (int n = 0; n < 16; n++) begin
      if (pad_oe[n])
        pad_level[n] = pad_out[n];
      else if (pull_field[2*n +: 2] == GPCFG_PULL_UP)
        pad_level[n] = 1'b1;
      else if (pull_field[2*n +: 2] == GPCFG_PULL_DOWN)
        pad_level[n] = 1'b0;
      else
        pad_level[n] = board_level[n];
    end
  end
endmodule // gpcfg_pads

// ===== gpcfg_port_tb_top.sv
`timescale 1ns/100ps
`include "gpcfg_regs.svh"
module gpcfg_port_tb_top
  import gpcfg_pkg::*;
;
  logic          clk_sys     = 1'b0;
  logic          sys_rst     = 1'b1;
  gpcfg_req_type bus_req     = '0;
  logic [15:0]   board_level = 16'h0000;
  logic [31:0]   bus_rdata;
  logic [31:0]   speed_field;
  logic [31:0]   pull_field;
  logic [15:0]   pad_in;
  logic [15:0]   pad_out;
  logic [15:0]   pad_oe;
  logic [15:0]   drive_type_bit;
  int            n_errors    = 0;
  int            check_count = 0;

  always #10 clk_sys = ~clk_sys;

  gpcfg_port #(.PORT_INDEX(0)) gpcfg_port_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .speed_field(speed_field),
    .pull_field(pull_field), .drive_type_bit(drive_type_bit));

  gpcfg_pads gpcfg_pads_i (
    .pad_out(pad_out), .pad_oe(pad_oe), .pull_field(pull_field),
    .board_level(board_level), .pad_level(pad_in));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    bus_req <= '{sel: 1'b1, wr: 1'b1, addr: a, be: be, wdata: d};
    @(posedge clk_sys);
    bus_req.sel <= 1'b0;
    // Let the write settle before a caller looks at the outputs
    #1;
  endtask

  // Read data stands for the one cycle after the request is taken
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    bus_req <= '{sel: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: 32'h0000_0000};
    @(posedge clk_sys);
    bus_req.sel <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask

  task tally_and_finish;
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`GPCFG_OFS_SPEED, `GPCFG_RST_SPEED_FIRST);
    rd(`GPCFG_OFS_PULL, `GPCFG_RST_PULL_FIRST);
    rd(`GPCFG_OFS_DRIVE, `GPCFG_RST_ZERO);
    rd(`GPCFG_OFS_LATCH, `GPCFG_RST_ZERO);
    rd(8'h30, `GPCFG_RST_ZERO);
    // Lane writes must leave the other bytes alone
    wr(`GPCFG_OFS_LATCH, 32'h0000_FFFF, 4'h1);
    rd(`GPCFG_OFS_LATCH, 32'h0000_00FF);
    wr(`GPCFG_OFS_LATCH, 32'h0000_8000, 4'h2);
    rd(`GPCFG_OFS_LATCH, 32'h0000_80FF);
    wr(`GPCFG_OFS_SETCLR, 32'h0080_0100, 4'hF);
    rd(`GPCFG_OFS_LATCH, 32'h0000_817F);
    wr(`GPCFG_OFS_SETCLR, 32'h0080_0080, 4'hF);
    rd(`GPCFG_OFS_LATCH, 32'h0000_81FF);
    rd(`GPCFG_OFS_SETCLR, `GPCFG_RST_ZERO);
    // Pin 0 open-drain at latch one floats onto its pull resistor
    wr(`GPCFG_OFS_DRIVE, 32'h0000_0001, 4'hF);
    wr(`GPCFG_OFS_PULL, 32'h0000_0001, 4'hF);
    repeat (3) @(posedge clk_sys);
    chk({pad_oe, pad_out}, 32'hFFFE_81FF);
    rd(`GPCFG_OFS_SAMPLE, 32'h0000_81FF);
    wr(`GPCFG_OFS_PULL, 32'h0000_0002, 4'hF);
    repeat (3) @(posedge clk_sys);
    rd(`GPCFG_OFS_SAMPLE, 32'h0000_81FE);
    wr(`GPCFG_OFS_SPEED, 32'hC000_0004, 4'hF);
    chk(speed_field, 32'hC000_0004);
    chk(pull_field, 32'h0000_0002);
    // Freeze pin 0, then arm the key
    wr(`GPCFG_OFS_FREEZE, 32'h0000_0001, 4'hF);
    wr(`GPCFG_OFS_FREEZE, 32'h0001_0001, 4'hF);
    wr(`GPCFG_OFS_FREEZE, 32'h0001_0001, 4'hF);
    rd(`GPCFG_OFS_FREEZE, 32'h0000_0001);
    rd(`GPCFG_OFS_FREEZE, 32'h0001_0001);
    wr(`GPCFG_OFS_PULL, 32'h0000_0004, 4'hF);
    rd(`GPCFG_OFS_PULL, 32'h0000_0006);
    wr(`GPCFG_OFS_SPEED, 32'hFFFF_FFFF, 4'hF);
    chk(speed_field, 32'hFFFF_FFFC);
    wr(`GPCFG_OFS_FREEZE, 32'h0000_0000, 4'hF);
    rd(`GPCFG_OFS_FREEZE, 32'h0001_0001);
    tally_and_finish;
  end

  // Whole run is under 200 cycles
  initial begin
    #(20 * 3000);
    n_errors++;
    tally_and_finish;
  end
endmodule // gpcfg_port_tb_top
